// ===== logic/tws_field_sync.sv
// Notes on behaviour
// RQ1: field_detect_n low when strength exceeds reference.
// RQ2: reference level set from two sense inputs.
// RQ3: four driven combinations give four steps.
// RQ4: both inputs open gives a fifth step.
// RQ5: other reader's power pulse asserts field_detect_n.
// RQ6: controller samples field_detect_n for nearby readers.
// RQ7: controller transmits together or after others.
// RQ8: controller writes by gapping transmitter after pulse.
// RQ9: every written bit has same period.
// RQ10: gap length alone encodes bit value.
// RQ11: controller should make gap lengths adjustable.
// RQ12: gaps measured at tx_on_n, not field.
// RQ13: 2 ms bit, 0.5/1.2 ms gaps nominal.
// RQ14: power stage runs only while tx_on_n low.
// RQ15: tx_on_n and tx_power_sel pulled up internally.
// RQ16: controller limits 50 ms reads to 4/s.
// RQ17: controller times gaps with its own counters.
// RQ18: controller synchronises field_detect_n in two stages.
`timescale 1ns/1ps
`default_nettype none
`include "tws_defs.svh"

module tws_field_sync #(
    parameter int RSSI_W = `TWS_RSSI_W
) (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic [RSSI_W-1:0]   rssi,
    input  wire tws_pkg::tws_sense_t sense,
    input  wire logic                tx_on_n_in,
    input  wire logic                tx_on_n_oe,
    input  wire logic                tx_power_sel_in,
    input  wire logic                tx_power_sel_oe,
    output logic                     field_detect_n,
    output logic                     tx_power_en,
    output logic                     tx_high_power,
    output logic [`TWS_STEP_W-1:0]   sense_step
);

    // one sensitivity step per driven combination, plus the open one
    localparam int NUM_STEPS = 5;

    typedef logic [`TWS_STEP_W-1:0] tws_step_t;

    // thresholds are fixed 8-bit constants, the strength path must match
    generate
        if (RSSI_W != `TWS_RSSI_W)
        begin : g_bad_width
            $error("tws_field_sync: RSSI_W must equal threshold width");
        end
    endgenerate

    generate
        if (NUM_STEPS > (1 << `TWS_STEP_W))
        begin : g_bad_steps
            $error("tws_field_sync: step code too narrow");
        end
    endgenerate

    // resolve a pin that may be undriven to its pulled-up level
    function automatic logic pulled(input logic val, input logic oe);
        pulled = oe ? val : `TWS_PULLUP_LEVEL;
    endfunction : pulled

    function automatic logic [`TWS_STEP_W-1:0] step_of(
        input tws_pkg::tws_sense_t s);
        if (!s.a.driven && !s.b.driven)
            step_of = `TWS_STEP_OPEN;
        else
            step_of = {1'b0, s.a.level, s.b.level};
    endfunction : step_of

    function automatic logic [RSSI_W-1:0] thr_of(
        input logic [`TWS_STEP_W-1:0] st);
        case (st)
            `TWS_STEP_LL: thr_of = `TWS_THR_LL;
            `TWS_STEP_LH: thr_of = `TWS_THR_LH;
            `TWS_STEP_HL: thr_of = `TWS_THR_HL;
            `TWS_STEP_HH: thr_of = `TWS_THR_HH;
            default:      thr_of = `TWS_THR_OPEN;
        endcase
    endfunction : thr_of

    // sensitivity step group
    tws_step_t              step_d;
    tws_step_t              step_q;

    // detection group
    logic [NUM_STEPS-1:0]   above;
    logic                   det_n_d;
    logic                   det_n_q;

    // transmitter group
    tws_pkg::tws_tx_state_t tx_d;
    tws_pkg::tws_tx_state_t tx_q;
    logic                   hp_d;
    logic                   hp_q;
    logic                   txn;
    logic                   power_on;

    // RQ2 RQ3 RQ4 step select
    always_comb
    begin
        step_d = step_of(sense);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            step_q <= `TWS_STEP_OPEN;
        end
        else
        begin
            step_q <= step_d;
        end
    end

    // RQ1 RQ5 one compare per step
    for (genvar g = 0; g < NUM_STEPS; g++)
    begin : g_above
        assign above[g] = (rssi > thr_of(tws_step_t'(g)));
    end

    // RQ1 RQ2 compare against registered step
    always_comb
    begin
        if (step_q < tws_step_t'(NUM_STEPS))
        begin
            det_n_d = !above[step_q];
        end
        else
        begin
            // unused codes fall back to the open step
            det_n_d = !above[`TWS_STEP_OPEN];
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            det_n_q <= 1'b1;
        end
        else
        begin
            det_n_q <= det_n_d;
        end
    end

    // RQ15 pull-up default on released pins
    always_comb
    begin
        txn  = pulled(tx_on_n_in, tx_on_n_oe);
        hp_d = pulled(tx_power_sel_in, tx_power_sel_oe);
        // RQ14 power stage gating
        case (txn)
            1'b0:    tx_d = tws_pkg::TWS_TX_ON;
            default: tx_d = tws_pkg::TWS_TX_OFF;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            tx_q <= tws_pkg::TWS_TX_OFF;
            hp_q <= 1'b1;
        end
        else
        begin
            tx_q <= tx_d;
            hp_q <= hp_d;
        end
    end

    // RQ14 stage runs only in the on state
    always_comb
    begin
        case (tx_q)
            tws_pkg::TWS_TX_ON:
            begin
                power_on = 1'b1;
            end
            default:
            begin
                power_on = 1'b0;
            end
        endcase
    end

    assign field_detect_n = det_n_q;
    assign tx_power_en    = power_on;
    assign tx_high_power  = hp_q;
    assign sense_step     = step_q;

endmodule : tws_field_sync

`default_nettype wire

// ===== shared/tws_defs.svh
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH

// sensitivity step codes (five distinct steps)
`define TWS_STEP_W        3
`define TWS_STEP_LL       3'h0
`define TWS_STEP_LH       3'h1
`define TWS_STEP_HL       3'h2
`define TWS_STEP_HH       3'h3
`define TWS_STEP_OPEN     3'h4

// default signal strength width and step thresholds
`define TWS_RSSI_W        8
`define TWS_THR_LL        8'h20
`define TWS_THR_LH        8'h40
`define TWS_THR_HL        8'h60
`define TWS_THR_HH        8'h80
`define TWS_THR_OPEN      8'h50

// clock and pull-up figures
`define TWS_CLK_HZ        50000000
`define TWS_PULLUP_LEVEL  1'h1

`endif

// ===== shared/tws_pkg.sv
package tws_pkg;

    // state of one sensitivity input pin: driven level or left open
    typedef struct packed {
        logic driven;
        logic level;
    } tws_sense_pin_t;

    typedef struct packed {
        tws_sense_pin_t a;
        tws_sense_pin_t b;
    } tws_sense_t;

    typedef enum logic [0:0] {
        TWS_TX_OFF,
        TWS_TX_ON
    } tws_tx_state_t;

endpackage : tws_pkg

// ===== testbench/tws_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module tws_ctrl_model #(
    parameter int BIT_CYC = 20,
    parameter int GAP_LOW = 5,
    parameter int GAP_HIGH = 12
) (
    input wire logic clock, go, field_detect_n,
    input wire logic [7:0] bits,
    output logic tx_on_n_in = 1'b0,
    output logic tx_on_n_oe = 1'b0
);
    int n = 0;
    logic pend = 1'b0, s1 = 1'b0, s2 = 1'b0;
    always @(posedge clock)
    begin
        s1 <= field_detect_n;
        s2 <= s1;
    end
    always @(negedge clock)
    begin
        if (n == 0)
        begin
            pend = pend | go;
            // start only when no other reader
            if (pend && s2)
            begin
                n = 1;
                pend = 1'b0;
            end
        end
        else
            n = n < 8 * BIT_CYC ? n + 1 : 0;
        tx_on_n_oe = n > 0;
        tx_on_n_in = n > 0 && (n - 1) % BIT_CYC <
            (bits[7 - (n - 1) / BIT_CYC] ? GAP_HIGH : GAP_LOW);
    end
endmodule : tws_ctrl_model
`default_nettype wire

// ===== testbench/tws_field_sync_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tws_field_sync_asserts #(parameter int RSSI_W = 8) (
    input wire logic clock, rst, tx_on_n_in, tx_on_n_oe,
    input wire logic tx_power_sel_in, tx_power_sel_oe, field_detect_n,
    input wire logic tx_power_en, tx_high_power,
    input wire logic [RSSI_W-1:0] rssi,
    input wire tws_pkg::tws_sense_t sense,
    input wire logic [2:0] sense_step
);
    wire [2:0] es = sense.a.driven | sense.b.driven ?
        {1'b0, sense.a.level, sense.b.level} : 3'h4;
    wire [7:0] th = sense_step[2] ? 8'h50 : {sense_step[1:0], 5'h0} + 8'h20;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    step_map_a: assert property (!$past(rst) |-> sense_step == $past(es))
        else $error("step code wrong");
    open_step_a: assert property (es[2] |=> sense_step == 3'h4)
        else $error("open step wrong");
    detect_level_a: assert property (!$past(rst) |->
        field_detect_n == !($past(rssi) > $past(th))) else $error("detect wrong");
    strong_pulse_a: assert property ($past(rssi) > 8'h80 && !$past(rst)
        |-> !field_detect_n) else $error("pulse missed");
    power_on_a: assert property (!$past(rst) |-> tx_power_en ==
        ($past(tx_on_n_oe) & !$past(tx_on_n_in))) else $error("power wrong");
    pullup_off_a: assert property (!tx_on_n_oe |=> !tx_power_en)
        else $error("released pin powers stage");
    power_sel_a: assert property (!$past(rst) |-> tx_high_power ==
        (!$past(tx_power_sel_oe) | $past(tx_power_sel_in))) else $error("sel");
endmodule : tws_field_sync_asserts
bind tws_field_sync tws_field_sync_asserts #(.RSSI_W(RSSI_W)) u_asserts (.*);
`default_nettype wire

// ===== testbench/tws_field_sync_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tws_field_sync_tb;
    logic clock = 0, rst = 1, go = 0, tx_power_sel_in = 0, tx_power_sel_oe = 0;
    logic [7:0] rssi = 8'h00, bits = 8'ha5;
    tws_pkg::tws_sense_t sense = 4'h0;
    logic field_detect_n, tx_power_en, tx_high_power, tx_on_n_in, tx_on_n_oe;
    logic [2:0] sense_step;
    int err_total = 0, cmp_count = 0, k = 0;
    always #10 clock = ~clock;
    tws_ctrl_model u_tws_ctrl_model (.clock(clock), .go(go), .bits(bits),
        .field_detect_n(field_detect_n), .tx_on_n_in(tx_on_n_in),
        .tx_on_n_oe(tx_on_n_oe));
    tws_field_sync u_tws_field_sync (.clock(clock), .rst(rst), .rssi(rssi),
        .sense(sense), .tx_on_n_in(tx_on_n_in), .tx_on_n_oe(tx_on_n_oe),
        .tx_power_sel_in(tx_power_sel_in),
        .tx_power_sel_oe(tx_power_sel_oe),
        .field_detect_n(field_detect_n), .tx_power_en(tx_power_en),
        .tx_high_power(tx_high_power), .sense_step(sense_step));
    task chk(string nm, logic [7:0] e, s);
        cmp_count++;
        err_total += (s !== e);
        if (s !== e)
            $display("unexpected %s exp %h got %h", nm, e, s);
    endtask : chk
    task results;
        $display("mismatches %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    task t_sense;
        for (int i = 0; i < 5; i++)
        begin
            sense = i == 4 ? 4'h0 : {1'b1, i[1], 1'b1, i[0]};
            rssi = i == 4 ? 8'h50 : 8'((i + 1) * 32);
            repeat (2) @(negedge clock);
            chk("step", 8'(i), 8'(sense_step));
            chk("detect", 1, 8'(field_detect_n));
            rssi++;
            repeat (2) @(negedge clock);
            chk("detect", 0, 8'(field_detect_n));
        end
    endtask : t_sense
    task t_reset;
        repeat (6) @(negedge clock);
        chk("reset step", 8'h04, 8'(sense_step));
        chk("reset detect", 8'h01, 8'(field_detect_n));
        chk("reset power", 8'h00, 8'(tx_power_en));
        chk("reset sel", 8'h01, 8'(tx_high_power));
        rst = 0;
    endtask : t_reset
    task t_write;
        chk("open sel", 8'h01, 8'(tx_high_power));
        // one write only, no read cycles
        tx_power_sel_oe = 1;
        go <= 1;
        @(negedge clock) go <= 0;
        repeat (10) @(negedge clock) k += tx_power_en;
        chk("held off", 8'h00, 8'(k));
        rssi = 8'h00;
        repeat (175) @(negedge clock) k += tx_power_en;
        chk("on time", 8'h5c, 8'(k));
        chk("high power", 8'h00, 8'(tx_high_power));
    endtask : t_write
    initial
    begin
        t_reset;
        t_sense;
        t_write;
        results;
    end
    initial
    begin
        repeat (2000) @(posedge clock);
        err_total++;
        results;
    end
endmodule : tws_field_sync_tb
`default_nettype wire
